// ### verilog/dsc_pkg.sv
/*
  Shared constants and types for the dual converter serial load control.
  Assumes a 24-bit serial word and at most a 16-bit converter code.
*/
`default_nettype none

package dsc_pkg;

  // Serial word length and bit counter values
  localparam int WORD_W = 24;
  localparam logic [4:0] BIT_CNT_RST = 5'h00;
  localparam logic [4:0] BIT_CNT_LAST = 5'h17;
  localparam logic [4:0] BIT_CNT_FULL = 5'h18;

  // Widest converter code carried in the data field
  localparam int CODE_W_MAX = 16;
  localparam logic [15:0] ZERO_CODE = 16'h0000;

  // Fastest serial clock the sender may use
  localparam int SER_CLK_MAX_MHZ = 50;
  localparam int SER_CLK_MIN_PERIOD_NS = 1000 / SER_CLK_MAX_MHZ;

  // Command field values
  localparam logic [2:0] CMD_WR_IN = 3'h0;
  localparam logic [2:0] CMD_UPD = 3'h1;
  localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
  localparam logic [2:0] CMD_WR_UPD = 3'h3;
  localparam logic [2:0] CMD_REF = 3'h7;

  // Address field values
  localparam logic [2:0] ADDR_ALL = 3'h7;

  // Values after reset, and the clear mode value loaded by clear
  localparam logic CLR_MODE_RST = 1'b0;
  localparam logic CLR_MODE_SET = 1'b1;
  localparam logic REF_INT_RST = 1'b0;
  localparam logic [4:0] SYNC_RST = 5'h0C;

  // One serial command word, first bit received at the top
  typedef struct packed {
    logic [1:0] spare;
    logic [2:0] cmd;
    logic [2:0] addr;
    logic [15:0] data;
  } dsc_word_t;

  // Status flags shown at the top level
  typedef struct packed {
    logic clear_mode;
    logic ref_internal;
  } dsc_status_t;

endpackage

`default_nettype wire

// ### verilog/dsc_sync.sv
/*
  Two-flop synchroniser for a bundle of independent level signals.
  Assumes each bit is a level or a toggle that holds for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // Both stages
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// ### verilog/dsc_serial_load.sv
/*
  Digital front end of a dual voltage-output converter: serial word receiver
  on the serial clock, input and converter registers, load strobe, clear and
  reference pin direction on the main clock.
  Assumes the serial clock stops while the frame input is high, and that the
  sender keeps each completed word for at least 24 serial clocks.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A low pulse on the load strobe copies pending input registers to converter registers.
// - A load strobe held low keeps converter registers updating without further pulses.
// - The clear input acts asynchronously, on its falling edge.
// - While clear is low, load strobe pulses have no effect.
// - Clear loads zero code into all input and converter registers.
// - Clear code mode ends at the 24th serial edge of the next frame.
// - Clear during a frame aborts it and drops the partial bits.
// - Frame input low enables the shift register; it is level sensitive.
// - The received word takes effect after the 24th serial clock.
// - Frame input rising before the 24th edge discards the write.
// - The shift register holds exactly 24 bits, one word per frame.
// - Serial data is sampled on each falling serial clock edge.
// - After power up the reference pin is an input.
// - Selecting the internal reference makes the reference pin drive.
// - Codes are straight binary of 12, 14 or 16 bits; zero is minimum.
module dsc_serial_load #(
  parameter int DAC_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ser_clk,
  input wire logic i_frame_n,
  input wire logic i_ser_data,
  input wire logic i_load_strobe_n,
  input wire logic i_async_clear_n,
  input wire logic i_shared_reference_pin_i,
  output logic o_shared_reference_pin_o,
  output logic o_shared_reference_pin_oe,
  output logic [DAC_W-1:0] o_dac_a,
  output logic [DAC_W-1:0] o_dac_b,
  output var dsc_pkg::dsc_status_t o_status,
  output logic o_ref_level
);

  import dsc_pkg::*;

  // Serial clock domain state
  logic frame_rst_n;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [WORD_W-1:0] sh_q;
  logic [WORD_W-1:0] sh_d;
  dsc_word_t word_q;
  dsc_word_t word_d;
  logic wtog_q;
  logic wtog_d;

  // Load strobe edge catcher
  logic ld_tog_q;
  logic ld_tog_d;

  // Synchronised inputs
  logic [4:0] sync_s;
  logic wtog_s;
  logic ltog_s;
  logic ld_lvl_s;
  logic clr_s;
  logic ref_pin_s;

  // Main clock domain state
  logic wtog_p_q;
  logic wtog_p_d;
  logic ltog_p_q;
  logic ltog_p_d;
  logic ref_int_q;
  logic ref_int_d;
  logic ref_lvl_q;
  logic ref_lvl_d;
  logic [DAC_W-1:0] in_q [2];
  logic [DAC_W-1:0] in_d [2];
  logic [DAC_W-1:0] dac_q [2];
  logic [DAC_W-1:0] dac_d [2];
  logic [1:0] pend_q;
  logic [1:0] pend_d;
  logic clr_mode_q;
  logic clr_mode_d;
  logic [1:0] sel;
  logic [DAC_W-1:0] code;
  logic word_evt;
  logic ld_edge;
  logic ld_go;

  // Frame counter runs only while frame is low and clear is high
  assign frame_rst_n = ~i_frame_n & i_async_clear_n;

  // Shift, count and capture of a complete word
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    word_d = word_q;
    wtog_d = wtog_q;
    if (cnt_q != BIT_CNT_FULL) begin
      sh_d = {sh_q[WORD_W-2:0], i_ser_data};
      cnt_d = cnt_q + 5'h01;
    end
    if (cnt_q == BIT_CNT_LAST) begin
      word_d = dsc_word_t'(sh_d);
      wtog_d = ~wtog_q;
    end
  end

  // Shift register, cleared whenever the frame ends or clear falls
  always_ff @(negedge i_ser_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= BIT_CNT_RST;
      sh_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  // Completed word and its toggle survive the end of frame
  always_ff @(negedge i_ser_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_q <= '0;
      wtog_q <= 1'b0;
    end else begin
      word_q <= word_d;
      wtog_q <= wtog_d;
    end
  end

  // Load strobe falling edge flips a toggle; pulses may be shorter than a clock
  always_comb begin
    ld_tog_d = ~ld_tog_q;
  end

  always_ff @(negedge i_load_strobe_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ld_tog_q <= 1'b0;
    end else begin
      ld_tog_q <= ld_tog_d;
    end
  end

  // Control signals crossing into the main clock; word_q is read directly without synchronisation
  dsc_sync #(
    .W(5),
    .RST(SYNC_RST)
  ) u_sync (
    .i_clk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_shared_reference_pin_i, i_async_clear_n, i_load_strobe_n, ld_tog_q, wtog_q}),
    .o_sync(sync_s)
  );

  assign wtog_s = sync_s[0];
  assign ltog_s = sync_s[1];
  assign ld_lvl_s = sync_s[2];
  assign clr_s = sync_s[3];
  assign ref_pin_s = sync_s[4];

  // Events seen on the main clock
  assign word_evt = wtog_s ^ wtog_p_q;
  assign ld_edge = ltog_s ^ ltog_p_q;
  assign ld_go = clr_s & (ld_edge | ~ld_lvl_s);
  assign code = word_q.data[CODE_W_MAX-1 -: DAC_W];

  // Edge trackers and reference selection
  always_comb begin
    wtog_p_d = wtog_s;
    ltog_p_d = ltog_s;
    ref_lvl_d = ref_pin_s;
    ref_int_d = ref_int_q;
    if (word_evt && (word_q.cmd == CMD_REF)) begin
      ref_int_d = word_q.data[0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wtog_p_q <= 1'b0;
      ltog_p_q <= 1'b0;
      ref_int_q <= REF_INT_RST;
      ref_lvl_q <= 1'b0;
    end else begin
      wtog_p_q <= wtog_p_d;
      ltog_p_q <= ltog_p_d;
      ref_int_q <= ref_int_d;
      ref_lvl_q <= ref_lvl_d;
    end
  end

  // Input and converter registers: load strobe first, then a new word
  always_comb begin
    in_d = in_q;
    dac_d = dac_q;
    pend_d = pend_q;
    clr_mode_d = clr_mode_q;
    sel = 2'h0;
    for (int ch = 0; ch < 2; ch++) begin
      sel[ch] = (word_q.addr == ADDR_ALL) || (word_q.addr == 3'(ch));
      if (ld_go && pend_q[ch]) begin
        dac_d[ch] = in_q[ch];
        pend_d[ch] = 1'b0;
      end
    end
    if (word_evt) begin
      clr_mode_d = 1'b0;
      for (int ch = 0; ch < 2; ch++) begin
        if (sel[ch]) begin
          case (word_q.cmd)
            CMD_WR_IN: begin
              in_d[ch] = code;
              pend_d[ch] = 1'b1;
            end
            CMD_UPD: begin
              dac_d[ch] = in_q[ch];
              pend_d[ch] = 1'b0;
            end
            CMD_WR_UPD: begin
              in_d[ch] = code;
              dac_d[ch] = code;
              pend_d[ch] = 1'b0;
            end
            CMD_WR_UPD_ALL: begin
              in_d[ch] = code;
            end
            default: begin
              in_d[ch] = in_d[ch];
            end
          endcase
        end
      end
      if (word_q.cmd == CMD_WR_UPD_ALL) begin
        dac_d = in_d;
        pend_d = 2'h0;
      end
    end
  end

  // Clear acts without the clock and holds the input and converter registers at zero code
  always_ff @(posedge i_mclk or negedge i_rst_n or negedge i_async_clear_n) begin
    if (!i_rst_n) begin
      in_q <= '{default: ZERO_CODE[DAC_W-1:0]};
      dac_q <= '{default: ZERO_CODE[DAC_W-1:0]};
      pend_q <= 2'h0;
      clr_mode_q <= CLR_MODE_RST;
    end else if (!i_async_clear_n) begin
      in_q <= '{default: ZERO_CODE[DAC_W-1:0]};
      dac_q <= '{default: ZERO_CODE[DAC_W-1:0]};
      pend_q <= 2'h0;
      clr_mode_q <= CLR_MODE_SET;
    end else begin
      in_q <= in_d;
      dac_q <= dac_d;
      pend_q <= pend_d;
      clr_mode_q <= clr_mode_d;
    end
  end

  // Outputs, all straight from flops
  assign o_dac_a = dac_q[0];
  assign o_dac_b = dac_q[1];
  assign o_status = '{clear_mode: clr_mode_q, ref_internal: ref_int_q};
  assign o_shared_reference_pin_o = ref_int_q;
  assign o_shared_reference_pin_oe = ref_int_q;
  assign o_ref_level = ref_lvl_q;

  // Checks on the serial side
  a_word_on_24th: assert property (
    @(negedge i_ser_clk) disable iff (!i_rst_n)
    (wtog_q != $past(wtog_q)) |-> ($past(cnt_q) == BIT_CNT_LAST)
  ) else $error("word taken on an edge other than the 24th");

  a_frame_abort: assert property (
    @(negedge i_ser_clk) disable iff (!i_rst_n)
    (!i_frame_n && !i_async_clear_n) |-> (cnt_q == BIT_CNT_RST)
  ) else $error("bit count kept while frame aborted");

  a_msb_order: assert property (
    @(negedge i_ser_clk) disable iff (!i_rst_n)
    (cnt_q == BIT_CNT_LAST) |=> (word_q[0] == $past(i_ser_data)) && (word_q[WORD_W-1] == $past(sh_q[WORD_W-2]))
  ) else $error("word bits not in arrival order");

  // Checks on the main clock side
  a_clear_zero_regs: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !i_async_clear_n |-> (in_q[0] == '0) && (in_q[1] == '0) && (dac_q[0] == '0) && (dac_q[1] == '0) && clr_mode_q
  ) else $error("registers not zero during clear");

  a_clear_ignores_load: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (!i_async_clear_n && !clr_s && ld_edge && !word_evt) |=> (dac_q[0] == '0) && (dac_q[1] == '0)
  ) else $error("load strobe acted during clear");

  a_strobe_copies: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_async_clear_n)
    (ld_go && pend_q[0] && !word_evt) |=> (dac_q[0] == $past(in_q[0])) && !pend_q[0]
  ) else $error("pending input not copied on load");

  // A channel with nothing pending shows its input code
  a_idle_regs_match: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (pend_q[0] || (dac_q[0] == in_q[0])) && (pend_q[1] || (dac_q[1] == in_q[1]))
  ) else $error("converter differs from input with nothing pending");

  // Write and update lands the received code in one step
  a_write_update: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_async_clear_n)
    (word_evt && (word_q.cmd == CMD_WR_UPD) && (word_q.addr == 3'h0))
      |=> (dac_q[0] == $past(word_q.data[CODE_W_MAX-1 -: DAC_W]))
  ) else $error("written code not in converter register");

  a_dac_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_async_clear_n)
    (!ld_go && !word_evt) |=> $stable(dac_q[0]) && $stable(dac_q[1])
  ) else $error("converter register changed without cause");

  a_tied_low_update: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_async_clear_n)
    (word_evt && (word_q.cmd == CMD_WR_IN) && !ld_lvl_s) ##1 (!ld_lvl_s && clr_s && !word_evt)
      |=> (dac_q[0] == $past(in_q[0])) && (dac_q[1] == $past(in_q[1]))
  ) else $error("held low strobe did not update");

  a_clear_mode_exit: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_async_clear_n)
    word_evt |=> !o_status.clear_mode
  ) else $error("clear mode kept after a full word");

  a_clear_mode_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n || !i_async_clear_n)
    (clr_mode_q && !word_evt) |=> clr_mode_q
  ) else $error("clear mode left without a word");

  a_ref_select: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (word_evt && (word_q.cmd == CMD_REF)) |=> (o_shared_reference_pin_oe == $past(word_q.data[0]))
  ) else $error("reference pin direction not set by command");

  a_ref_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !(word_evt && (word_q.cmd == CMD_REF)) |=> $stable(o_shared_reference_pin_oe)
  ) else $error("reference pin direction changed by itself");

endmodule

`default_nettype wire

// ### testbench/dsc_host_model.sv
/*
  Host model that writes serial words to the converter front end.
  Assumes the bench calls send and leaves one frame running at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_host_model (
  output logic o_ser_clk,
  output logic o_frame_n,
  output logic o_ser_data
);
  localparam realtime HALF = 62.5;

  // Idle: frame high, clock stands high between frames
  initial begin
    o_ser_clk = 1'b1;
    o_frame_n = 1'b1;
    o_ser_data = 1'b0;
  end

  // One frame of nbits, top bit first; data moves after the rising edge
  task automatic send(input logic [23:0] w, input int nbits);
    #(7.3);
    o_frame_n = 1'b0;
    #(HALF);
    for (int i = 0; i < nbits; i++) begin
      o_ser_data = w[23 - i];
      #(HALF);
      o_ser_clk = 1'b0;
      #(HALF);
      o_ser_clk = 1'b1;
    end
    #(HALF);
    o_frame_n = 1'b1;
    o_ser_data = ~o_ser_data; // Released line no longer shows the last bit
    #(100);
  endtask
endmodule

`default_nettype wire

// ### testbench/dsc_serial_load_tb.sv
/*
  Self-checking bench for the serial load control block.
  Assumes the host model drives the serial side and the bench the rest.
*/
`timescale 1ns/1ps
`default_nettype none

module dsc_serial_load_tb;
  import dsc_pkg::*;

  logic i_mclk, i_rst_n, ser_clk, frame_n, ser_data, load_strobe_n, async_clear_n, ext_ref;
  logic ref_o, ref_oe, ref_level;
  logic [15:0] dac_a, dac_b;
  dsc_status_t status;
  int errors, checks_done;
  // Reference pin level from both drivers
  wire logic ref_wire = ref_oe ? ref_o : ext_ref;

  dsc_host_model i_dsc_host_model (.o_ser_clk(ser_clk), .o_frame_n(frame_n), .o_ser_data(ser_data));

  dsc_serial_load #(.DAC_W(16)) i_dsc_serial_load (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ser_clk(ser_clk), .i_frame_n(frame_n),
    .i_ser_data(ser_data), .i_load_strobe_n(load_strobe_n), .i_async_clear_n(async_clear_n),
    .i_shared_reference_pin_i(ref_wire), .o_shared_reference_pin_o(ref_o),
    .o_shared_reference_pin_oe(ref_oe), .o_dac_a(dac_a), .o_dac_b(dac_b),
    .o_status(status), .o_ref_level(ref_level)
  );

  // Main clock, 50 ns period
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] mk(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d);
    return {2'h0, c, a, d};
  endfunction

  // Full word, then room for the 2 to 3 cycle answer
  task automatic put(input logic [23:0] w);
    i_dsc_host_model.send(w, 24);
    cyc(8);
  endtask

  task automatic strobe();
    load_strobe_n = 1'b0;
    cyc(2);
    load_strobe_n = 1'b1;
    cyc(8);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_reset();
    chk(dac_a, 16'h0000);
    chk({14'h0, status}, 16'h0000);
    chk({15'h0, ref_oe}, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_write();
    put(mk(CMD_WR_UPD, 3'h0, 16'h1234));
    chk(dac_a, 16'h1234);
    chk(dac_b, 16'h0000);
    put(mk(CMD_WR_UPD_ALL, ADDR_ALL, 16'hFFFF));
    chk(dac_a, 16'hFFFF);
    chk(dac_b, 16'hFFFF);
    put(mk(CMD_WR_IN, 3'h0, 16'h0F0F));
    chk(dac_a, 16'hFFFF);
    put(mk(CMD_UPD, 3'h0, 16'h0000));
    chk(dac_a, 16'h0F0F);
    $display("test write done");
  endtask

  task automatic t_strobe();
    put(mk(CMD_WR_IN, 3'h1, 16'hABCD));
    chk(dac_b, 16'hFFFF);
    strobe();
    chk(dac_b, 16'hABCD);
    chk(dac_a, 16'h0F0F);
    $display("test strobe done");
  endtask

  task automatic t_short();
    i_dsc_host_model.send(mk(CMD_WR_UPD, 3'h0, 16'h5555), 20);
    cyc(8);
    chk(dac_a, 16'h0F0F);
    $display("test short frame done");
  endtask

  task automatic t_clear();
    put(mk(CMD_WR_IN, 3'h0, 16'h7777));
    async_clear_n = 1'b0;
    #1;
    chk(dac_a, 16'h0000);
    chk(dac_b, 16'h0000);
    cyc(3);
    chk({14'h0, status}, 16'h0002);
    strobe();
    chk(dac_a, 16'h0000);
    async_clear_n = 1'b1;
    cyc(4);
    strobe();
    chk(dac_a, 16'h0000);
    chk({14'h0, status}, 16'h0002);
    put(mk(CMD_WR_UPD, 3'h1, 16'h0042));
    chk(dac_b, 16'h0042);
    chk({14'h0, status}, 16'h0000);
    $display("test clear done");
  endtask

  task automatic t_abort();
    fork
      i_dsc_host_model.send(mk(CMD_WR_UPD, 3'h0, 16'h9999), 24);
      begin
        cyc(25);
        async_clear_n = 1'b0;
        cyc(2);
        async_clear_n = 1'b1;
      end
    join
    cyc(8);
    chk(dac_a, 16'h0000);
    chk({14'h0, status}, 16'h0002);
    $display("test abort done");
  endtask

  task automatic t_held();
    load_strobe_n = 1'b0;
    put(mk(CMD_WR_IN, 3'h0, 16'h0123));
    chk(dac_a, 16'h0123);
    load_strobe_n = 1'b1;
    cyc(4);
    $display("test held strobe done");
  endtask

  task automatic t_ref();
    ext_ref = 1'b1;
    cyc(4);
    chk({15'h0, ref_level}, 16'h0001);
    put(mk(CMD_REF, 3'h0, 16'h0001));
    ext_ref = 1'b0;
    cyc(4);
    chk({15'h0, ref_oe}, 16'h0001);
    chk({15'h0, ref_o}, 16'h0001);
    chk({14'h0, status}, 16'h0001);
    chk({15'h0, ref_level}, 16'h0001);
    put(mk(CMD_REF, 3'h0, 16'h0000));
    chk({15'h0, ref_oe}, 16'h0000);
    chk({15'h0, ref_level}, 16'h0000);
    $display("test reference done");
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    conclude();
  end

  // Reset, then the scenarios in order
  initial begin
    errors = 0;
    checks_done = 0;
    i_rst_n = 1'b0;
    load_strobe_n = 1'b1;
    async_clear_n = 1'b1;
    ext_ref = 1'b0;
    cyc(12);
    i_rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_write();
    t_strobe();
    t_short();
    t_clear();
    t_abort();
    t_held();
    t_ref();
    conclude();
  end
endmodule

`default_nettype wire
